// ==== hbdrv_pkg.sv ====
// shared constants and types for the h-bridge driver control bank
// assumes an 8-bit apb byte address with one register per aligned word
`default_nettype none
package hbdrv_pkg;
  localparam int unsigned HBDRV_ADDR_W = 8;
  localparam int unsigned HBDRV_DATA_W = 32;
  localparam int unsigned HBDRV_PIN_W  = 4;

  // register indices; the byte address is four times the index
  localparam logic [3:0] IDX_DEVICE_CONTROL   = 4'h4;
  localparam logic [3:0] IDX_BRIDGE_CONTROL   = 4'h5;
  localparam logic [3:0] IDX_HS_DRIVE_CURRENT = 4'h6;
  localparam logic [3:0] IDX_FAULT_STATUS     = 4'hf;

  // device_control fields
  localparam int unsigned DC_ENABLE_BIT  = 7;
  localparam int unsigned DC_SPREAD_SPECTRUM_DISABLE_BIT = 6;
  localparam int unsigned DC_IN1_SEL_BIT = 5;
  localparam int unsigned DC_IN2_SEL_BIT = 4;
  localparam int unsigned DC_LOCK_LSB    = 1;
  localparam int unsigned DC_CLEAR_BIT   = 0;
  // bridge_control fields
  localparam int unsigned BC_HANDSHAKE_BIT = 7;
  localparam int unsigned BC_SCHEME_LSB    = 5;
  localparam int unsigned BC_FREEWHEEL_BIT = 4;
  localparam int unsigned BC_SOFT_IN1_BIT  = 3;
  localparam int unsigned BC_SOFT_IN2_BIT  = 2;
  localparam int unsigned BC_FLOAT1_BIT    = 1;
  localparam int unsigned BC_FLOAT2_BIT    = 0;
  // high_side_drive_current fields
  localparam int unsigned HC_SOURCE_LSB = 4;
  localparam int unsigned HC_SINK_LSB   = 0;
  // fault_status fields
  localparam int unsigned FS_FAULT_BIT  = 0;
  localparam int unsigned FS_LOCKED_BIT = 1;

  localparam logic [2:0] LOCK_OPEN = 3'h3;
  localparam logic [2:0] LOCK_SHUT = 3'h6;

  localparam logic [7:0] DEVICE_CONTROL_RESET   = 8'h06;
  localparam logic [7:0] BRIDGE_CONTROL_RESET   = 8'h00;
  localparam logic [7:0] HS_DRIVE_CURRENT_RESET = 8'hff;

  typedef enum logic [1:0] {
    SCHEME_INDEPENDENT,
    SCHEME_PHASE_ENABLE,
    SCHEME_PWM,
    SCHEME_SPLIT
  } hbdrv_scheme_t;

  function automatic logic [HBDRV_ADDR_W-1:0] reg_addr(input logic [3:0] idx);
    reg_addr = {2'b00, idx, 2'b00};
  endfunction
endpackage
`default_nettype wire

// ==== hbdrv_cfg_if.sv ====
// configuration and synchronised pin levels from the register bank to the drive stage
// assumes both ends run on the register bank clock
`timescale 1ns/1ps
`default_nettype none
interface hbdrv_cfg_if;
  import hbdrv_pkg::*;
  logic          driver_enable;
  logic          ssc_disable;
  logic          in1_sel;
  logic          in2_sel;
  logic          handshake_disable;
  hbdrv_scheme_t scheme;
  logic          freewheel;
  logic          soft_in1;
  logic          soft_in2;
  logic          soft_float1;
  logic          soft_float2;
  logic [3:0]    source_code;
  logic [3:0]    sink_code;
  logic          pin_in1;
  logic          pin_in2;
  logic          pin_float1;
  logic          pin_float2;
  modport regs (output driver_enable, ssc_disable, in1_sel, in2_sel, handshake_disable,
                scheme, freewheel, soft_in1, soft_in2, soft_float1, soft_float2,
                source_code, sink_code, pin_in1, pin_in2, pin_float1, pin_float2);
  modport drive (input driver_enable, ssc_disable, in1_sel, in2_sel, handshake_disable,
                 scheme, freewheel, soft_in1, soft_in2, soft_float1, soft_float2,
                 source_code, sink_code, pin_in1, pin_in2, pin_float1, pin_float2);
endinterface
`default_nettype wire

// ==== hbdrv_sync.sv ====
// two-flop synchroniser bank for asynchronous pin levels
// assumes inputs are slow levels; a pulse shorter than one clock can be missed
`timescale 1ns/1ps
`default_nettype none
module hbdrv_sync #(
  parameter int unsigned WIDTH = 4
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             clk_en,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  // meta_q feeds only sync_q
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q <= '0;
      sync_q <= '0;
    end else if (clk_en) begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;
endmodule
`default_nettype wire

// ==== hbdrv_drive.sv ====
// drive stage: input source routing, float gating and registered gate commands
// assumes configuration and pins arrive already in the pclk domain
`timescale 1ns/1ps
`default_nettype none
module hbdrv_drive (
  input  wire logic    pclk,
  input  wire logic    presetn,
  input  wire logic    clk_en,
  hbdrv_cfg_if.drive   cfg,
  output logic         driver_enable,
  output logic         gate_pulldown,
  output logic         spread_spectrum_enable,
  output logic         handshake_enable,
  output logic [1:0]   bridge_input_scheme,
  output logic         freewheel_side,
  output logic         gate_input1,
  output logic         gate_input2,
  output logic         float_half1,
  output logic         float_half2,
  output logic [3:0]   high_side_source_current,
  output logic [3:0]   high_side_sink_current
);
  import hbdrv_pkg::*;

  wire logic sel_in1 = cfg.in1_sel ? cfg.soft_in1 : cfg.pin_in1;
  wire logic sel_in2 = cfg.in2_sel ? cfg.soft_in2 : cfg.pin_in2;
  wire logic req1    = cfg.soft_float1 | cfg.pin_float1;
  wire logic req2    = cfg.soft_float2 | cfg.pin_float2;
  logic      float_allowed;

  // float requests only count for independent half-bridges
  always_comb begin
    unique case (cfg.scheme)
      SCHEME_INDEPENDENT:  float_allowed = 1'b1;
      SCHEME_PHASE_ENABLE: float_allowed = 1'b0;
      SCHEME_PWM:          float_allowed = 1'b0;
      SCHEME_SPLIT:        float_allowed = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      driver_enable            <= DEVICE_CONTROL_RESET[DC_ENABLE_BIT];
      gate_pulldown            <= ~DEVICE_CONTROL_RESET[DC_ENABLE_BIT];
      spread_spectrum_enable   <= ~DEVICE_CONTROL_RESET[DC_SPREAD_SPECTRUM_DISABLE_BIT];
      handshake_enable         <= ~BRIDGE_CONTROL_RESET[BC_HANDSHAKE_BIT];
      bridge_input_scheme      <= BRIDGE_CONTROL_RESET[BC_SCHEME_LSB +: 2];
      freewheel_side           <= BRIDGE_CONTROL_RESET[BC_FREEWHEEL_BIT];
      gate_input1              <= 1'b0;
      gate_input2              <= 1'b0;
      float_half1              <= 1'b0;
      float_half2              <= 1'b0;
      high_side_source_current <= HS_DRIVE_CURRENT_RESET[HC_SOURCE_LSB +: 4];
      high_side_sink_current   <= HS_DRIVE_CURRENT_RESET[HC_SINK_LSB +: 4];
    end else if (clk_en) begin
      driver_enable            <= cfg.driver_enable;
      gate_pulldown            <= ~cfg.driver_enable | (float_allowed & (req1 | req2));
      spread_spectrum_enable   <= ~cfg.ssc_disable;
      handshake_enable         <= ~cfg.handshake_disable;
      bridge_input_scheme      <= cfg.scheme;
      freewheel_side           <= cfg.freewheel;
      gate_input1              <= cfg.driver_enable & sel_in1 & ~(float_allowed & req1);
      gate_input2              <= cfg.driver_enable & sel_in2 & ~(float_allowed & req2);
      float_half1              <= float_allowed & req1;
      float_half2              <= float_allowed & req2;
      high_side_source_current <= cfg.source_code;
      high_side_sink_current   <= cfg.sink_code;
    end
  end
endmodule
`default_nettype wire

// ==== hbdrv_ctrl_regs.sv ====
// apb register bank for the h-bridge gate driver control registers
// assumes an apb master on pclk; pins arrive asynchronously, fault_event on pclk
//
// Functional notes
// - enable bit 7 low ignores inputs, holds pulldowns; high lets inputs drive gates
// - spread-spectrum disable bit low keeps spreading on, high turns it off
// - bit 5 picks input 1 from its pin at 0, software bit at 1
// - bit 4 picks input 2 from its pin at 0, software bit at 1
// - lock field code 011b unlocks all control registers; it resets to that code
// - lock code 110b locks; later writes dropped except to the lock field
// - other lock codes written to bits 3-1 leave lock state unchanged
// - fault-clear bit written 1 clears latched faults, then returns to 0 itself
// - handshake disable 0 uses gate-voltage handshake, 1 uses drive and dead times only
// - bridge mode 00 independent, 01 phase/enable, 10 pwm, 11 split solenoid control
// - freewheel bit 0 picks low-side freewheeling, 1 picks high-side
// - software input-1 bit 3 drives input 1 when software source is selected
// - software input-2 bit 2 drives input 2 when software source is selected
// - independent mode: software bit 1 or pin floats half-bridge 1
// - independent mode: software bit 0 or pin floats half-bridge 2
// - drive current bits 7-4 hold high-side source code, reset 1111b
// - drive current bits 3-0 hold high-side sink code, reset 1111b
// - device control sits at index 4h and resets to 6h
`timescale 1ns/1ps
`default_nettype none
module hbdrv_ctrl_regs (
  input  wire logic                              pclk,
  input  wire logic                              presetn,
  input  wire logic                              clk_en,
  input  wire logic [hbdrv_pkg::HBDRV_ADDR_W-1:0] paddr,
  input  wire logic                              psel,
  input  wire logic                              penable,
  input  wire logic                              pwrite,
  input  wire logic [hbdrv_pkg::HBDRV_DATA_W-1:0] pwdata,
  input  wire logic [3:0]                        pstrb,
  output logic      [hbdrv_pkg::HBDRV_DATA_W-1:0] prdata,
  output logic                                   pready,
  output logic                                   pslverr,
  input  wire logic                              input1_pin,
  input  wire logic                              input2_pin,
  input  wire logic                              float_pin_half1,
  input  wire logic                              float_pin_half2,
  input  wire logic                              fault_event,
  output logic                                   driver_enable,
  output logic                                   gate_pulldown,
  output logic                                   spread_spectrum_enable,
  output logic                                   handshake_enable,
  output logic      [1:0]                        bridge_input_scheme,
  output logic                                   freewheel_side,
  output logic                                   gate_input1,
  output logic                                   gate_input2,
  output logic                                   float_half1,
  output logic                                   float_half2,
  output logic      [3:0]                        high_side_source_current,
  output logic      [3:0]                        high_side_sink_current,
  output logic                                   fault_clear_pulse,
  output logic                                   registers_locked,
  output logic                                   fault_latched
);
  import hbdrv_pkg::*;

  // device_control state
  logic       drv_en_q;
  logic       spread_spectrum_disable_q;
  logic       in1_sel_q;
  logic       in2_sel_q;
  logic [2:0] lock_q;
  logic       locked_q;
  logic       clear_q;
  // bridge_control state
  logic          hs_dis_q;
  hbdrv_scheme_t scheme_q;
  logic          freewheel_q;
  logic          soft_in1_q;
  logic          soft_in2_q;
  logic          soft_float1_q;
  logic          soft_float2_q;
  // high_side_drive_current state
  logic [3:0] source_q;
  logic [3:0] sink_q;
  // fault latch
  logic       fault_q;
  // bus answer
  logic                    pready_q;
  logic                    pslverr_q;
  logic [HBDRV_DATA_W-1:0] prdata_q;

  logic [HBDRV_PIN_W-1:0] pins_sync;
  hbdrv_cfg_if            cfg ();

  // address decode
  wire logic hit_dc = paddr == reg_addr(IDX_DEVICE_CONTROL);
  wire logic hit_bc = paddr == reg_addr(IDX_BRIDGE_CONTROL);
  wire logic hit_hc = paddr == reg_addr(IDX_HS_DRIVE_CURRENT);
  wire logic hit_fs = paddr == reg_addr(IDX_FAULT_STATUS);
  wire logic mapped = hit_dc | hit_bc | hit_hc | hit_fs;

  // apb phases; one wait state, pready high for one cycle
  wire logic access       = psel & penable;
  wire logic first_access = access & ~pready_q;
  wire logic done         = access & pready_q;
  wire logic wr_done      = done & pwrite & pstrb[0];

  // write strobes; fault_status is read-only
  wire logic wr_dc = wr_done & hit_dc;
  wire logic wr_bc = wr_done & hit_bc & ~locked_q;
  wire logic wr_hc = wr_done & hit_hc & ~locked_q;
  wire logic wr_dc_body = wr_dc & ~locked_q;

  // lock field handling
  wire logic [2:0] lock_code  = pwdata[DC_LOCK_LSB +: 3];
  wire logic       lock_open  = lock_code == LOCK_OPEN;
  wire logic       lock_shut  = lock_code == LOCK_SHUT;
  wire logic       lock_valid = lock_open | lock_shut;
  wire logic       lock_load  = wr_dc & lock_valid;

  // read data
  wire logic [7:0] rd_dc = {drv_en_q, spread_spectrum_disable_q, in1_sel_q, in2_sel_q, lock_q, clear_q};
  wire logic [7:0] rd_bc = {hs_dis_q, scheme_q, freewheel_q, soft_in1_q, soft_in2_q,
                            soft_float1_q, soft_float2_q};
  wire logic [7:0] rd_hc = {source_q, sink_q};
  wire logic [7:0] rd_fs = {6'h00, locked_q, fault_q};
  wire logic [7:0] rd_byte = hit_dc ? rd_dc :
                             hit_bc ? rd_bc :
                             hit_hc ? rd_hc :
                             hit_fs ? rd_fs : 8'h00;

  // apb answer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end else if (clk_en) begin
      pready_q  <= first_access;
      pslverr_q <= first_access & ~mapped;
      prdata_q  <= (first_access & ~pwrite) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
    end
  end

  // enable, spread spectrum and input source select
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      drv_en_q  <= DEVICE_CONTROL_RESET[DC_ENABLE_BIT];
      spread_spectrum_disable_q <= DEVICE_CONTROL_RESET[DC_SPREAD_SPECTRUM_DISABLE_BIT];
      in1_sel_q <= DEVICE_CONTROL_RESET[DC_IN1_SEL_BIT];
      in2_sel_q <= DEVICE_CONTROL_RESET[DC_IN2_SEL_BIT];
    end else if (clk_en && wr_dc_body) begin
      drv_en_q  <= pwdata[DC_ENABLE_BIT];
      spread_spectrum_disable_q <= pwdata[DC_SPREAD_SPECTRUM_DISABLE_BIT];
      in1_sel_q <= pwdata[DC_IN1_SEL_BIT];
      in2_sel_q <= pwdata[DC_IN2_SEL_BIT];
    end
  end

  // lock field stays writable while locked so software can reopen
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lock_q   <= DEVICE_CONTROL_RESET[DC_LOCK_LSB +: 3];
      locked_q <= 1'b0;
    end else if (clk_en && lock_load) begin
      lock_q   <= lock_code;
      locked_q <= lock_shut;
    end
  end

  // fault clear reads back 1 for one cycle, then drops by itself
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clear_q <= DEVICE_CONTROL_RESET[DC_CLEAR_BIT];
    end else if (clk_en) begin
      clear_q <= wr_dc_body & pwdata[DC_CLEAR_BIT];
    end
  end

  // a new fault in the clearing cycle wins over the clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault_q <= 1'b0;
    end else if (clk_en) begin
      fault_q <= fault_event | (fault_q & ~clear_q);
    end
  end

  // bridge control fields
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hs_dis_q      <= BRIDGE_CONTROL_RESET[BC_HANDSHAKE_BIT];
      scheme_q      <= hbdrv_scheme_t'(BRIDGE_CONTROL_RESET[BC_SCHEME_LSB +: 2]);
      freewheel_q   <= BRIDGE_CONTROL_RESET[BC_FREEWHEEL_BIT];
      soft_in1_q    <= BRIDGE_CONTROL_RESET[BC_SOFT_IN1_BIT];
      soft_in2_q    <= BRIDGE_CONTROL_RESET[BC_SOFT_IN2_BIT];
      soft_float1_q <= BRIDGE_CONTROL_RESET[BC_FLOAT1_BIT];
      soft_float2_q <= BRIDGE_CONTROL_RESET[BC_FLOAT2_BIT];
    end else if (clk_en && wr_bc) begin
      hs_dis_q      <= pwdata[BC_HANDSHAKE_BIT];
      scheme_q      <= hbdrv_scheme_t'(pwdata[BC_SCHEME_LSB +: 2]);
      freewheel_q   <= pwdata[BC_FREEWHEEL_BIT];
      soft_in1_q    <= pwdata[BC_SOFT_IN1_BIT];
      soft_in2_q    <= pwdata[BC_SOFT_IN2_BIT];
      soft_float1_q <= pwdata[BC_FLOAT1_BIT];
      soft_float2_q <= pwdata[BC_FLOAT2_BIT];
    end
  end

  // high-side gate current codes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      source_q <= HS_DRIVE_CURRENT_RESET[HC_SOURCE_LSB +: 4];
      sink_q   <= HS_DRIVE_CURRENT_RESET[HC_SINK_LSB +: 4];
    end else if (clk_en && wr_hc) begin
      source_q <= pwdata[HC_SOURCE_LSB +: 4];
      sink_q   <= pwdata[HC_SINK_LSB +: 4];
    end
  end

  // pins cross into pclk before any routing looks at them
  hbdrv_sync #(
    .WIDTH (HBDRV_PIN_W)
  ) u_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .clk_en   (clk_en),
    .async_in ({float_pin_half2, float_pin_half1, input2_pin, input1_pin}),
    .sync_out (pins_sync)
  );

  assign cfg.driver_enable     = drv_en_q;
  assign cfg.ssc_disable       = spread_spectrum_disable_q;
  assign cfg.in1_sel           = in1_sel_q;
  assign cfg.in2_sel           = in2_sel_q;
  assign cfg.handshake_disable = hs_dis_q;
  assign cfg.scheme            = scheme_q;
  assign cfg.freewheel         = freewheel_q;
  assign cfg.soft_in1          = soft_in1_q;
  assign cfg.soft_in2          = soft_in2_q;
  assign cfg.soft_float1       = soft_float1_q;
  assign cfg.soft_float2       = soft_float2_q;
  assign cfg.source_code       = source_q;
  assign cfg.sink_code         = sink_q;
  assign cfg.pin_in1           = pins_sync[0];
  assign cfg.pin_in2           = pins_sync[1];
  assign cfg.pin_float1        = pins_sync[2];
  assign cfg.pin_float2        = pins_sync[3];

  // drive stage registers every gate-facing output
  hbdrv_drive u_drive (
    .pclk                     (pclk),
    .presetn                  (presetn),
    .clk_en                   (clk_en),
    .cfg                      (cfg.drive),
    .driver_enable            (driver_enable),
    .gate_pulldown            (gate_pulldown),
    .spread_spectrum_enable   (spread_spectrum_enable),
    .handshake_enable         (handshake_enable),
    .bridge_input_scheme      (bridge_input_scheme),
    .freewheel_side           (freewheel_side),
    .gate_input1              (gate_input1),
    .gate_input2              (gate_input2),
    .float_half1              (float_half1),
    .float_half2              (float_half2),
    .high_side_source_current (high_side_source_current),
    .high_side_sink_current   (high_side_sink_current)
  );

  assign prdata            = prdata_q;
  assign pready            = pready_q;
  assign pslverr           = pslverr_q;
  assign fault_clear_pulse = clear_q;
  assign registers_locked  = locked_q;
  assign fault_latched     = fault_q;
endmodule
`default_nettype wire

// ==== hbdrv_ctrl_regs_asserts.sv ====
// assertion checker for the h-bridge control register bank, bound to its ports
// assumes clk_en stays high across transfers and all byte strobes are set
`timescale 1ns/1ps
`default_nettype none
module hbdrv_ctrl_regs_asserts (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        clk_en,
  input wire logic [7:0]  paddr,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        fault_event,
  input wire logic        driver_enable,
  input wire logic        gate_pulldown,
  input wire logic        spread_spectrum_enable,
  input wire logic        handshake_enable,
  input wire logic [1:0]  bridge_input_scheme,
  input wire logic        freewheel_side,
  input wire logic        gate_input1,
  input wire logic        gate_input2,
  input wire logic        float_half1,
  input wire logic        float_half2,
  input wire logic [3:0]  high_side_source_current,
  input wire logic [3:0]  high_side_sink_current,
  input wire logic        fault_clear_pulse,
  input wire logic        registers_locked,
  input wire logic        fault_latched
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire logic wr_done = psel && penable && pready && pwrite && clk_en;
  wire logic wr_dc   = wr_done && paddr == 8'h10;
  wire logic wr_bc   = wr_done && paddr == 8'h14;
  wire logic wr_cu   = wr_done && paddr == 8'h18;
  sequence s_setup;
    psel && !penable && clk_en;
  endsequence
  sequence s_access;
    psel && penable && clk_en;
  endsequence
  a_one_wait: assert property (s_setup ##1 s_access |=> pready)
    else $error("no answer after one wait state");
  a_ready_pulse: assert property (pready && clk_en |=> !pready)
    else $error("ready held longer than one cycle");
  a_err_mapped: assert property (s_access and pready && paddr == 8'h10 |-> !pslverr)
    else $error("error on the device control address");
  a_off_gates: assert property (!driver_enable |-> gate_pulldown && !gate_input1 && !gate_input2)
    else $error("gates driven while disabled");
  a_float_one: assert property (float_half1 |-> bridge_input_scheme == 2'b00 && !gate_input1 && gate_pulldown)
    else $error("half one float wrong");
  a_float_two: assert property (float_half2 |-> bridge_input_scheme == 2'b00 && !gate_input2 && gate_pulldown)
    else $error("half two float wrong");
  a_ctrl_apply: assert property (wr_dc && !registers_locked |=> ##1
    driver_enable == $past(pwdata[7], 2) && spread_spectrum_enable != $past(pwdata[6], 2))
    else $error("device control write not applied");
  a_brg_apply: assert property (wr_bc && !registers_locked |=> ##1
    bridge_input_scheme == $past(pwdata[6:5], 2) && freewheel_side == $past(pwdata[4], 2)
    && handshake_enable != $past(pwdata[7], 2))
    else $error("bridge control write not applied");
  a_cur_apply: assert property (wr_cu && !registers_locked |=> ##1
    {high_side_source_current, high_side_sink_current} == $past(pwdata[7:0], 2))
    else $error("drive current write not applied");
  a_lock_hold: assert property (wr_bc && registers_locked |=> ##1
    bridge_input_scheme == $past(bridge_input_scheme, 2) && freewheel_side == $past(freewheel_side, 2))
    else $error("locked bridge write took effect");
  a_clear_once: assert property (fault_clear_pulse && clk_en |=> !fault_clear_pulse)
    else $error("clear pulse longer than one cycle");
  a_clear_fault: assert property (fault_clear_pulse && !fault_event && clk_en |=> !fault_latched)
    else $error("fault not cleared");
endmodule
bind hbdrv_ctrl_regs hbdrv_ctrl_regs_asserts u_hbdrv_ctrl_regs_asserts (.*);
`default_nettype wire

// ==== hbdrv_host_model.sv ====
// host controller model issuing apb register transfers
// assumes callers enter just after a rising edge of pclk
`timescale 1ns/1ps
`default_nettype none
module hbdrv_host_model (
  input  wire logic        pclk,
  input  wire logic        pready,
  input  wire logic        pslverr,
  input  wire logic [31:0] prdata,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata,
  output logic [3:0]       pstrb
);
  initial {psel, penable, pwrite, paddr, pwdata, pstrb} = {3'b000, 8'h00, 32'h0000_0000, 4'hf};
  // gap sets idle cycles so the host can be prompt or slow
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input int gap, output logic [31:0] r, output logic e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // released data lines never keep the old value
    pwdata <= ~d;
    repeat (gap + 1) @(posedge pclk);
  endtask
endmodule
`default_nettype wire

// ==== hbdrv_ctrl_regs_tb_top.sv ====
// self-checking bench for the h-bridge control register bank
// assumes the host model drives apb and the bench drives pins and faults
`timescale 1ns/1ps
`default_nettype none
module hbdrv_ctrl_regs_tb_top;
  import hbdrv_pkg::*;
  logic        pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr, err;
  logic        input1_pin, input2_pin, float_pin_half1, float_pin_half2, fault_event;
  logic        driver_enable, gate_pulldown, spread_spectrum_enable, handshake_enable;
  logic        freewheel_side, gate_input1, gate_input2, float_half1, float_half2;
  logic        fault_clear_pulse, registers_locked, fault_latched;
  logic [1:0]  bridge_input_scheme;
  logic [3:0]  pstrb, high_side_source_current, high_side_sink_current;
  logic [7:0]  paddr, cu;
  logic [31:0] pwdata, prdata, rd, seed, dc, bc;
  int          bad_count, tests_run;
  hbdrv_ctrl_regs u_hbdrv_ctrl_regs (.*);
  hbdrv_host_model u_hbdrv_host_model (.pclk, .pready, .pslverr, .prdata, .psel, .penable,
    .pwrite, .paddr, .pwdata, .pstrb);
  always #2 pclk = ~pclk;
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  // p holds input1, input2, float1, float2 pin levels
  function automatic logic [3:0] exp_drive(input logic [7:0] d, b, input logic [3:0] p);
    logic i1, i2, f1, f2;
    i1 = d[DC_IN1_SEL_BIT] ? b[BC_SOFT_IN1_BIT] : p[3];
    i2 = d[DC_IN2_SEL_BIT] ? b[BC_SOFT_IN2_BIT] : p[2];
    f1 = b[6:5] == 2'b00 && (b[BC_FLOAT1_BIT] || p[1]);
    f2 = b[6:5] == 2'b00 && (b[BC_FLOAT2_BIT] || p[0]);
    return {d[7] & i1 & ~f1, d[7] & i2 & ~f2, f1, f2};
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    u_hbdrv_host_model.xfer(1'b1, a, d, int'(seed[29:28]), rd, err);
  endtask
  task automatic rdr(input logic [7:0] a);
    u_hbdrv_host_model.xfer(1'b0, a, 32'h0000_0000, 0, rd, err);
  endtask
  task automatic results;
    $display("checks %0d wrong %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    #200_000;
    bad_count++;
    results();
  end
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    clk_en = 1'b1;
    seed = 32'hd105_cbb7;
    {input1_pin, input2_pin, float_pin_half1, float_pin_half2, fault_event} = 5'h00;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    check({driver_enable, gate_pulldown}, 2'b01);
    rdr(8'h10); check(rd, 32'h0000_0006);
    rdr(8'h14); check(rd, 32'h0000_0000);
    rdr(8'h18); check(rd, 32'h0000_00ff);
    rdr(8'h1c); check({err, rd[30:0]}, 32'h8000_0000);
    $display("test reset done");
    for (int i = 0; i < 24; i++) begin
      seed = xs(seed);
      dc = {24'h0, seed[23] | i[2], seed[22:20], 4'b0110};
      bc = {24'h0, seed[7], i[1:0], seed[4:0]};
      cu = seed[15:8];
      {input1_pin, input2_pin, float_pin_half1, float_pin_half2} <= seed[27:24];
      wr(8'h10, dc);
      wr(8'h14, bc);
      wr(8'h18, {24'h0, cu});
      rdr(8'h14); check(rd, bc);
      rdr(8'h18); check(rd, {24'h0, cu});
      check({bridge_input_scheme, freewheel_side, !handshake_enable}, {bc[6:4], bc[7]});
      check({high_side_source_current, high_side_sink_current}, cu);
      check(spread_spectrum_enable, !dc[6]);
      check({gate_input1, gate_input2, float_half1, float_half2},
            exp_drive(dc[7:0], bc[7:0], seed[27:24]));
    end
    $display("test routing done");
    wr(8'h10, 32'h0000_008c);
    check(registers_locked, 1'b1);
    wr(8'h14, 32'h0000_00ff);
    wr(8'h18, 32'h0000_0000);
    wr(8'h10, 32'h0000_000a);
    rdr(8'h14); check(rd, bc);
    rdr(8'h18); check(rd, {24'h0, cu});
    rdr(8'h10); check(rd, 32'h0000_008c);
    wr(8'h10, 32'h0000_0006);
    check(registers_locked, 1'b0);
    rdr(8'h10); check(rd, 32'h0000_0086);
    wr(8'h14, 32'h0000_0060);
    rdr(8'h14); check(rd, 32'h0000_0060);
    $display("test lock done");
    fault_event <= 1'b1;
    @(posedge pclk);
    fault_event <= 1'b0;
    @(posedge pclk);
    check(fault_latched, 1'b1);
    wr(8'h10, 32'h0000_0007);
    rdr(8'h3c); check(rd[0], 1'b0);
    rdr(8'h10); check(rd, 32'h0000_0006);
    $display("test fault clear done");
    results();
  end
endmodule
`default_nettype wire
